// ---- dpuia_pkg.sv ----
package dpuia_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_FLAGS = 8'h08;
  localparam logic [7:0] ADR_MR0 = 8'h10;
  localparam logic [7:0] ADR_MR1 = 8'h14;
  localparam logic [7:0] ADR_MR2 = 8'h18;
  localparam logic [7:0] ADR_MR3 = 8'h1C;
  localparam logic CFG_RESET = 1'h1;

  // Sticky error flags
  localparam int FLAG_W = 7;
  localparam int F_CKE_EARLY = 0;
  localparam int F_CKE_DROP = 1;
  localparam int F_ODT_MOVE = 2;
  localparam int F_XPR = 3;
  localparam int F_ORDER = 4;
  localparam int F_NO_ROW = 5;
  localparam int F_NOT_READY = 6;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int INIT_WAIT_US = 500;
  localparam int INIT_CYC_DEF = (INIT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TXS_NS = 200;
  localparam int TXPR_TCK = 5;
  localparam int TXS_CYC = (TXS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] TXPR_CYC = 3'((TXS_CYC > TXPR_TCK) ? TXS_CYC : TXPR_TCK);
  localparam logic [9:0] DLLK_CYC = 10'h200;
  localparam logic [9:0] ZQINIT_CYC = 10'h200;

  // ----------------------------------------
  // Commands {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_ZQ = 4'h6;
  localparam logic [3:0] CMD_DES = 4'h8;

  // Address bit positions
  localparam int A_DLL_OFF = 0;
  localparam int A_BT = 3;
  localparam int A_DLL_RST = 8;
  localparam int A_AP = 10;
  localparam int A_BC = 12;
  // Nominal termination select bits of MR1
  localparam int A_RTT0 = 2;
  localparam int A_RTT1 = 6;
  localparam int A_RTT2 = 9;
  localparam int MR0_BL_LSB = 0;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [2:0] MR_SEL0 = 3'h0;
  localparam logic [2:0] MR_SEL1 = 3'h1;
  localparam logic [3:0][2:0] MR_ORDER = {3'h0, 3'h1, 3'h3, 3'h2};
  localparam logic [1:0] MR_LAST = 2'h3;
  localparam logic [1:0] PAIR_LAST8 = 2'h3;
  localparam logic [1:0] PAIR_LAST4 = 2'h1;

  localparam int DQ_W = 16;
  localparam int CORE_W = 8 * DQ_W;
  localparam int MEM_DEPTH = 16;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_INIT = 3'h1,
    ST_WAIT_CKE = 3'h2,
    ST_MRS = 3'h3,
    ST_ZQ = 3'h4,
    ST_CAL = 3'h5,
    ST_READY = 3'h6
  } dpuia_state_t;

  typedef struct packed {
    logic rst_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [2:0] ba;
    logic [13:0] a;
    logic [DQ_W-1:0] dq_rise;
    logic [DQ_W-1:0] dq_fall;
  } dpuia_pin_t;

  typedef struct packed {
    logic [13:0] pad;
    logic [1:0] mr_step;
    logic [7:0] row_open;
    logic ready;
    logic busy;
    logic zq_busy;
    logic dll_busy;
    logic cke_seen;
    logic [2:0] st;
  } dpuia_status_t;

endpackage

// ---- dpuia_sync.sv ----
module dpuia_sync
  import dpuia_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pins
  input wire dpuia_pin_t i_pin,
  output dpuia_pin_t o_pin
);

  typedef struct packed {
    dpuia_pin_t meta;
    dpuia_pin_t sync;
  } dpuia_sync_t;

  dpuia_sync_t r_reg;
  dpuia_sync_t r_next;

  always_comb
  begin
    r_next.meta = i_pin;
    r_next.sync = r_reg.meta;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign o_pin = r_reg.sync;

endmodule

// ---- dpuia_burst.sv ----
module dpuia_burst
  import dpuia_pkg::*;
(
  // Burst position
  input wire logic [2:0] i_start,
  input wire logic i_interleave,
  input wire logic [1:0] i_pair,
  // Columns of the two beats
  output logic [2:0] o_col_rise,
  output logic [2:0] o_col_fall
);

  // Sequential wraps inside the nibble, interleaved flips address bits
  function automatic logic [2:0] beat_col(input logic [2:0] start, input logic il, input logic [2:0] beat);
    logic [1:0] low;
    low = start[1:0] + beat[1:0];
    return il ? (start ^ beat) : {start[2] ^ beat[2], low};
  endfunction

  assign o_col_rise = beat_col(i_start, i_interleave, {i_pair, 1'b0});
  assign o_col_fall = beat_col(i_start, i_interleave, {i_pair, 1'b1});

endmodule

// ---- dpuia_top.sv ----
// Overview of operation
// - Accesses are bursts of eight or four
// - Eight-beat word moves over four clocks
// - Column, auto precharge and on-fly chop
// - Internal init runs without external clock
// - Termination off until CKE registered high
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
module dpuia_top
  import dpuia_pkg::*;
#(
  parameter int P_INIT_CYC = INIT_CYC_DEF
)
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // Memory pins
  input wire logic I_RESET_N,
  input wire logic I_CKE,
  input wire logic I_CS_N,
  input wire logic I_RAS_N,
  input wire logic I_CAS_N,
  input wire logic I_WE_N,
  input wire logic I_ODT,
  input wire logic [2:0] I_BA,
  input wire logic [13:0] I_A,
  // Data pins, two beats per clock
  input wire logic [15:0] I_DQ_RISE,
  input wire logic [15:0] I_DQ_FALL,
  output logic [15:0] O_DQ_RISE,
  output logic [15:0] O_DQ_FALL,
  output logic O_DQ_OE_N,
  output logic O_ODT_TERM,
  output logic O_READY,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK
);

  typedef struct packed {
    dpuia_state_t st;
    logic [15:0] cnt;
    logic [2:0] txpr;
    logic [9:0] dllk;
    logic [9:0] zq;
    logic [1:0] mr_step;
    logic [3:0][13:0] mr;
    logic cke_seen;
    logic odt_hold;
    logic [7:0] row_open;
    logic busy;
    logic wr;
    logic bc4;
    logic il;
    logic [1:0] pair;
    logic [2:0] bank;
    logic col3;
    logic [2:0] scol;
    logic [DQ_W-1:0] dq_r;
    logic [DQ_W-1:0] dq_f;
    logic oe_n;
    logic term;
    logic ready;
    logic [FLAG_W-1:0] flags;
    logic cfg;
    logic ack;
    logic [31:0] dat;
    logic [MEM_DEPTH-1:0][CORE_W-1:0] mem;
  } dpuia_regs_t;

  dpuia_regs_t r_reg;
  dpuia_regs_t r_next;
  dpuia_pin_t pin_raw;
  dpuia_pin_t s;
  dpuia_status_t status;
  logic [3:0] cmd;
  logic cmd_ok;
  logic rdwr;
  logic take;
  logic bc4_sel;
  logic [1:0] bl_mode;
  logic [3:0] mem_idx;
  logic [2:0] col_r;
  logic [2:0] col_f;

  function automatic logic [3:0] cmd_of(input dpuia_pin_t p);
    return p.cs_n ? CMD_DES : {p.cs_n, p.ras_n, p.cas_n, p.we_n};
  endfunction

  // ----------------------------------------
  // Pin capture and burst ordering
  // ----------------------------------------
  assign pin_raw = '{rst_n: I_RESET_N, cke: I_CKE, cs_n: I_CS_N, ras_n: I_RAS_N, cas_n: I_CAS_N,
                     we_n: I_WE_N, odt: I_ODT, ba: I_BA, a: I_A, dq_rise: I_DQ_RISE, dq_fall: I_DQ_FALL};

  dpuia_sync u_sync (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_pin(pin_raw),
    .o_pin(s)
  );

  dpuia_burst u_burst (
    .i_start(r_reg.scol),
    .i_interleave(r_reg.il),
    .i_pair(r_reg.pair),
    .o_col_rise(col_r),
    .o_col_fall(col_f)
  );

  assign cmd = cmd_of(s);
  assign cmd_ok = s.cke && s.rst_n;
  assign rdwr = cmd_ok && (cmd == CMD_RD || cmd == CMD_WR);
  assign take = rdwr && r_reg.st == ST_READY && r_reg.row_open[s.ba] && !r_reg.busy;
  assign bl_mode = r_reg.mr[0][MR0_BL_LSB +: 2];
  assign bc4_sel = (bl_mode == BL_FIX4) || (bl_mode == BL_OTF && !s.a[A_BC]);
  assign mem_idx = {r_reg.bank, r_reg.col3};
  assign status = '{pad: '0, mr_step: r_reg.mr_step, row_open: r_reg.row_open, ready: r_reg.ready,
                    busy: r_reg.busy, zq_busy: r_reg.zq != '0, dll_busy: r_reg.dllk != '0,
                    cke_seen: r_reg.cke_seen, st: r_reg.st};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [FLAG_W-1:0] set;
    logic [FLAG_W-1:0] clr;
    set = '0;
    clr = '0;
    r_next = r_reg;
    // Register bus, answer one cycle after the request
    r_next.ack = I_WB_CYC && I_WB_STB && !r_reg.ack;
    case (I_WB_ADR)
      ADR_CFG: r_next.dat = 32'(r_reg.cfg);
      ADR_STATUS: r_next.dat = status;
      ADR_FLAGS: r_next.dat = 32'(r_reg.flags);
      ADR_MR0: r_next.dat = 32'(r_reg.mr[0]);
      ADR_MR1: r_next.dat = 32'(r_reg.mr[1]);
      ADR_MR2: r_next.dat = 32'(r_reg.mr[2]);
      ADR_MR3: r_next.dat = 32'(r_reg.mr[3]);
      default: r_next.dat = 32'h0;
    endcase
    if (r_reg.ack && I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_SEL[0])
    begin
      if (I_WB_ADR == ADR_CFG)
      begin
        r_next.cfg = I_WB_DAT[0];
      end
      if (I_WB_ADR == ADR_FLAGS)
      begin
        clr = I_WB_DAT[FLAG_W-1:0];
      end
    end
    if (r_reg.dllk != '0)
    begin
      r_next.dllk = r_reg.dllk - 10'h1;
    end
    if (r_reg.zq != '0)
    begin
      r_next.zq = r_reg.zq - 10'h1;
    end
    // Initialization sequence
    case (r_reg.st)
      ST_RESET:
      begin
        if (s.rst_n)
        begin
          r_next.st = ST_INIT;
          r_next.cnt = 16'(P_INIT_CYC - 1);
        end
      end
      ST_INIT:
      begin
        if (s.cke)
        begin
          set[F_CKE_EARLY] = 1'b1;
        end
        if (r_reg.cnt == '0)
        begin
          r_next.st = ST_WAIT_CKE;
        end
        else
        begin
          r_next.cnt = r_reg.cnt - 16'h1;
        end
      end
      ST_WAIT_CKE:
      begin
        if (s.cke)
        begin
          r_next.cke_seen = 1'b1;
          r_next.odt_hold = s.odt;
          r_next.txpr = TXPR_CYC;
          r_next.st = ST_MRS;
        end
      end
      ST_MRS:
      begin
        if (r_reg.txpr != '0)
        begin
          r_next.txpr = r_reg.txpr - 3'h1;
        end
        if (cmd_ok && cmd == CMD_MRS)
        begin
          if (r_reg.txpr != '0)
          begin
            set[F_XPR] = 1'b1;
          end
          if (s.ba != MR_ORDER[r_reg.mr_step] || (s.ba == MR_SEL1 && s.a[A_DLL_OFF])
              || (s.ba == MR_SEL0 && !s.a[A_DLL_RST]))
          begin
            set[F_ORDER] = 1'b1;
          end
          if (s.ba == MR_SEL0 && s.a[A_DLL_RST])
          begin
            r_next.dllk = DLLK_CYC;
          end
          r_next.mr_step = r_reg.mr_step + 2'h1;
          if (r_reg.mr_step == MR_LAST)
          begin
            r_next.st = ST_ZQ;
          end
        end
      end
      ST_ZQ:
      begin
        if (cmd_ok && cmd == CMD_ZQ && s.a[A_AP])
        begin
          r_next.zq = ZQINIT_CYC;
          r_next.st = ST_CAL;
        end
      end
      ST_CAL:
      begin
        if (r_reg.dllk == '0 && r_reg.zq == '0)
        begin
          r_next.st = ST_READY;
        end
      end
      ST_READY:
      begin
        if (cmd_ok && cmd == CMD_ACT)
        begin
          r_next.row_open[s.ba] = 1'b1;
        end
        if (cmd_ok && cmd == CMD_PRE)
        begin
          if (s.a[A_AP])
          begin
            r_next.row_open = '0;
          end
          else
          begin
            r_next.row_open[s.ba] = 1'b0;
          end
        end
        if (rdwr && !r_reg.row_open[s.ba])
        begin
          set[F_NO_ROW] = 1'b1;
        end
      end
      default: r_next.st = ST_RESET;
    endcase
    // Mode register contents replace whole words
    if (cmd_ok && cmd == CMD_MRS && !s.ba[2] && (r_reg.st == ST_MRS || r_reg.st == ST_READY))
    begin
      r_next.mr[s.ba[1:0]] = s.a;
    end
    if (r_reg.cke_seen && r_reg.st != ST_READY && s.rst_n)
    begin
      if (!s.cke)
      begin
        set[F_CKE_DROP] = 1'b1;
      end
      if (s.odt != r_reg.odt_hold || (s.odt && (r_reg.mr[1][A_RTT0] | r_reg.mr[1][A_RTT1] | r_reg.mr[1][A_RTT2])))
      begin
        set[F_ODT_MOVE] = 1'b1;
      end
      if (rdwr || (cmd_ok && cmd == CMD_ACT))
      begin
        set[F_NOT_READY] = 1'b1;
      end
    end
    // Burst data path, two beats per clock
    r_next.oe_n = 1'b1;
    if (r_reg.busy)
    begin
      if (r_reg.wr)
      begin
        r_next.mem[mem_idx][{col_r, 4'h0} +: DQ_W] = s.dq_rise;
        r_next.mem[mem_idx][{col_f, 4'h0} +: DQ_W] = s.dq_fall;
      end
      else
      begin
        r_next.dq_r = r_reg.mem[mem_idx][{col_r, 4'h0} +: DQ_W];
        r_next.dq_f = r_reg.mem[mem_idx][{col_f, 4'h0} +: DQ_W];
        r_next.oe_n = 1'b0;
      end
      r_next.pair = r_reg.pair + 2'h1;
      if (r_reg.pair == (r_reg.bc4 ? PAIR_LAST4 : PAIR_LAST8))
      begin
        r_next.busy = 1'b0;
      end
    end
    if (take)
    begin
      r_next.busy = 1'b1;
      r_next.pair = 2'h0;
      r_next.wr = (cmd == CMD_WR);
      r_next.bc4 = bc4_sel;
      r_next.il = r_reg.mr[0][A_BT];
      r_next.bank = s.ba;
      r_next.col3 = s.a[3];
      if (cmd == CMD_WR)
      begin
        r_next.scol = bc4_sel ? {s.a[2], 2'h0} : 3'h0;
      end
      else
      begin
        r_next.scol = s.a[2:0];
      end
      if (s.a[A_AP])
      begin
        r_next.row_open[s.ba] = 1'b0;
      end
    end
    // Pin reset restarts initialization; a running burst finishes
    if (!s.rst_n)
    begin
      r_next.st = ST_RESET;
      r_next.cke_seen = 1'b0;
      r_next.row_open = '0;
      r_next.dllk = '0;
      r_next.zq = '0;
      r_next.mr_step = '0;
    end
    r_next.term = s.rst_n && r_reg.cke_seen && s.odt && r_reg.cfg;
    r_next.ready = (r_next.st == ST_READY);
    r_next.flags = (r_reg.flags & ~clr) | set;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      r_reg <= '{st: ST_RESET, oe_n: 1'b1, cfg: CFG_RESET, default: '0};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign O_DQ_RISE = r_reg.dq_r;
  assign O_DQ_FALL = r_reg.dq_f;
  assign O_DQ_OE_N = r_reg.oe_n;
  assign O_ODT_TERM = r_reg.term;
  assign O_READY = r_reg.ready;
  assign O_WB_DAT = r_reg.dat;
  assign O_WB_ACK = r_reg.ack;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  a_burst_eight_rd: assert property (
    take && cmd == CMD_RD && !bc4_sel |=> ##1 !O_DQ_OE_N [*4] ##1 O_DQ_OE_N)
    else $error("eight-beat read not four clocks");
  a_burst_chop_rd: assert property (
    take && cmd == CMD_RD && bc4_sel |=> ##1 !O_DQ_OE_N [*2] ##1 O_DQ_OE_N)
    else $error("chopped read not two clocks");
  a_prefetch_four: assert property (
    take && !bc4_sel |=> r_reg.busy [*4] ##1 !r_reg.busy)
    else $error("full burst not four core clocks");
  a_otf_chop_sel: assert property (
    take && bl_mode == BL_OTF |=> r_reg.bc4 == !$past(s.a[A_BC]))
    else $error("on-the-fly chop select wrong");
  a_auto_precharge: assert property (
    take && s.a[A_AP] |=> !r_reg.row_open[r_reg.bank])
    else $error("auto precharge left row open");
  a_init_clockless: assert property (
    r_reg.st == ST_INIT && r_reg.cnt != '0 && s.rst_n |=> r_reg.st == ST_INIT && r_reg.cnt == $past(r_reg.cnt) - 16'h1)
    else $error("internal init stalled");
  a_odt_before_cke: assert property (
    O_ODT_TERM |-> $past(r_reg.cke_seen))
    else $error("termination before CKE registered");
  a_odt_in_reset: assert property (
    !s.rst_n [*2] |-> !O_ODT_TERM)
    else $error("termination during reset");
  a_mrs_order_flag: assert property (
    r_reg.st == ST_MRS && cmd_ok && cmd == CMD_MRS && s.ba != MR_ORDER[r_reg.mr_step] |=> r_reg.flags[F_ORDER])
    else $error("mode register order error not flagged");
  a_cke_drop_flag: assert property (
    r_reg.cke_seen && r_reg.st != ST_READY && s.rst_n && !s.cke |=> r_reg.flags[F_CKE_DROP])
    else $error("CKE drop not flagged");

  c_ready: cover property (r_reg.st == ST_CAL ##1 r_reg.st == ST_READY);
  c_chop_read: cover property (take && cmd == CMD_RD && bc4_sel);
  c_full_write: cover property (take && cmd == CMD_WR && !bc4_sel);

endmodule

// ---- dpuia_ctrl_model.sv ----
module dpuia_ctrl_model
  import dpuia_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Memory pins
  output dpuia_pin_t o_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_pin = '0;
    o_pin.odt = 1'b1;
    {o_pin.cs_n, o_pin.ras_n, o_pin.cas_n, o_pin.we_n} = CMD_DES;
  end

  // One pin cycle; deselected address and idle data lines keep toggling
  task automatic step(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a,
                      input logic drv, input logic [15:0] r, input logic [15:0] f);
    @(posedge i_clk);
    {o_pin.cs_n, o_pin.ras_n, o_pin.cas_n, o_pin.we_n} <= c;
    o_pin.ba <= (c == CMD_DES) ? ~o_pin.ba : ba;
    o_pin.a <= (c == CMD_DES) ? ~o_pin.a : a;
    o_pin.dq_rise <= drv ? r : ~o_pin.dq_rise;
    o_pin.dq_fall <= drv ? f : ~o_pin.dq_fall;
  endtask

  task automatic idle(input int n);
    repeat (n) step(CMD_DES, 3'h0, 14'h0000, 1'b0, 16'h0000, 16'h0000);
  endtask

  task automatic cmd(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a);
    step(c, ba, a, 1'b0, 16'h0000, 16'h0000);
    idle(2);
  endtask

  // Reset pulse, CKE already low well before release
  task automatic hold_reset(input int n);
    @(posedge i_clk);
    o_pin.rst_n <= 1'b0;
    o_pin.cke <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_pin.rst_n <= 1'b1;
  endtask

  // Deselect registered on the running clock, then CKE held high
  task automatic cke_up();
    idle(1);
    @(posedge i_clk);
    o_pin.cke <= 1'b1;
  endtask

  // Termination request changes only once the device is ready
  task automatic set_odt(input logic v);
    @(posedge i_clk);
    o_pin.odt <= v;
  endtask

  task automatic mode_regs(input logic [13:0] mr2, input logic [13:0] mr3,
                           input logic [13:0] mr1, input logic [13:0] mr0);
    idle(int'(TXPR_CYC) + 1);
    cmd(CMD_MRS, 3'h2, mr2);
    cmd(CMD_MRS, 3'h3, mr3);
    cmd(CMD_MRS, 3'h1, mr1 & 14'h3FFE);
    cmd(CMD_MRS, 3'h0, mr0 | 14'h0100);
    cmd(CMD_ZQ, 3'h0, 14'h0400);
  endtask

  // Eight-beat write, two beats per clock after the command
  task automatic write8(input logic [2:0] ba, input logic [13:0] a, input logic [15:0] base);
    step(CMD_WR, ba, a, 1'b0, 16'h0000, 16'h0000);
    for (int k = 0; k < 8; k += 2)
      step(CMD_DES, 3'h0, 14'h0000, 1'b1, base + 16'(k), base + 16'(k + 1));
    idle(2);
  endtask
endmodule

// ---- tb.sv ----
module tb;
  import dpuia_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P_INIT = 20;
  logic clk, rst, cyc, stb, we, ack, oe_n, term, ready;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, rd;
  logic [3:0] sel, wsel;
  logic ilv;
  logic [15:0] dq_r, dq_f;
  int err_count, compares;
  dpuia_pin_t pin;

  dpuia_ctrl_model i_ctrl (.i_clk(clk), .o_pin(pin));
  dpuia_top #(.P_INIT_CYC(P_INIT)) i_dut (
    .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_RESET_N(pin.rst_n), .I_CKE(pin.cke),
    .I_CS_N(pin.cs_n), .I_RAS_N(pin.ras_n), .I_CAS_N(pin.cas_n), .I_WE_N(pin.we_n),
    .I_ODT(pin.odt), .I_BA(pin.ba), .I_A(pin.a), .I_DQ_RISE(pin.dq_rise), .I_DQ_FALL(pin.dq_fall),
    .O_DQ_RISE(dq_r), .O_DQ_FALL(dq_f), .O_DQ_OE_N(oe_n), .O_ODT_TERM(term), .O_READY(ready),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic end_sim();
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout();
    err_count++;
    end_sim();
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= wsel;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 20)
        timeout();
    end
    while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // Sequential order: low half wraps, second half flips column bit 2
  task automatic beats(input int pairs, input logic [2:0] s, input logic [15:0] base);
    int n = 0;
    logic [2:0] c;
    while (oe_n !== 1'b0)
    begin
      @(negedge clk);
      n++;
      if (n > 20)
        timeout();
    end
    for (int i = 0; i < 2 * pairs; i += 2)
    begin
      c = ilv ? (s ^ 3'(i)) : {s[2] ^ (i >= 4), 2'(s[1:0] + i)};
      chk({16'h0, dq_r}, {16'h0, base + 16'(c)});
      c = ilv ? (s ^ 3'(i + 1)) : {s[2] ^ (i + 1 >= 4), 2'(s[1:0] + i + 1)};
      chk({16'h0, dq_f}, {16'h0, base + 16'(c)});
      @(negedge clk);
    end
    chk({31'h0, oe_n}, 32'h1);
  endtask

  task automatic rd_burst(input logic [13:0] a, input int pairs, input logic [15:0] base);
    fork
      i_ctrl.cmd(CMD_RD, 3'h2, a);
      beats(pairs, a[2:0], base);
    join
  endtask

  task automatic init(input int rst_cyc, input logic [13:0] mr0);
    int n = 0;
    i_ctrl.hold_reset(rst_cyc);
    i_ctrl.idle(4);
    @(negedge clk);
    chk({30'h0, ready, term}, 32'h0);
    rchk(ADR_STATUS, 32'h7, 32'h1);
    i_ctrl.idle(P_INIT);
    rchk(ADR_STATUS, 32'hF, 32'h2);
    chk({31'h0, term}, 32'h0);
    i_ctrl.cke_up();
    i_ctrl.idle(4);
    @(negedge clk);
    chk({31'h0, term}, 32'h1);
    i_ctrl.mode_regs(14'h0008, 14'h0000, 14'h0000, mr0);
    @(negedge clk);
    chk({31'h0, ready}, 32'h0);
    while (ready !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 3000)
        timeout();
    end
    rchk(ADR_STATUS, 32'hFFFF, 32'h008E);
    rchk(ADR_FLAGS, 32'hFFFF_FFFF, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rst, cyc, stb, we, adr, wdat, sel, ilv, err_count, compares} = '0;
    wsel = 4'hF;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(ADR_CFG, 32'hFFFF_FFFF, 32'h1);
    rchk(ADR_MR2, 32'hFFFF_FFFF, 32'h0);
    rchk(8'h40, 32'hFFFF_FFFF, 32'h0);
    init(5000, 14'h0001);
    rchk(ADR_MR2, 32'h3FFF, 32'h0008);
    i_ctrl.cmd(CMD_ACT, 3'h2, 14'h0155);
    rchk(ADR_STATUS, 32'hFF00, 32'h0400);
    i_ctrl.write8(3'h2, 14'h1000, 16'hA000);
    i_ctrl.idle(4);
    rd_burst(14'h1001, 4, 16'hA000);
    rd_burst(14'h0006, 2, 16'hA000);
    rd_burst(14'h1403, 4, 16'hA000);
    rchk(ADR_STATUS, 32'hFF00, 32'h0);
    i_ctrl.cmd(CMD_RD, 3'h2, 14'h1000);
    i_ctrl.idle(6);
    rchk(ADR_FLAGS, 32'hFFFF_FFFF, 32'h20);
    wb(1'b1, ADR_FLAGS, 32'h20);
    rchk(ADR_FLAGS, 32'hFFFF_FFFF, 32'h0);
    wb(1'b1, ADR_CFG, 32'h0);
    i_ctrl.idle(3);
    @(negedge clk);
    chk({31'h0, term}, 32'h0);
    wb(1'b1, ADR_CFG, 32'h1);
    i_ctrl.idle(3);
    @(negedge clk);
    chk({31'h0, term}, 32'h1);
    wsel = 4'hE;
    wb(1'b1, ADR_CFG, 32'h0);
    wsel = 4'hF;
    rchk(ADR_CFG, 32'hFFFF_FFFF, 32'h1);
    init(3, 14'h0008);
    i_ctrl.cmd(CMD_ACT, 3'h2, 14'h0155);
    ilv = 1'b1;
    rd_burst(14'h0001, 4, 16'hA000);
    i_ctrl.set_odt(1'b0);
    i_ctrl.idle(3);
    @(negedge clk);
    chk({31'h0, term}, 32'h0);
    end_sim();
  end
endmodule
